//--- bbs_shifter.sv
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Small valid/ready FIFO for queued items.
module bbs_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;

  // Full and empty come straight from the pointer difference.
  assign in_ready  = (wp_q - rp_q) != (AW+1)'(D); // Pointer width, so D itself is seen.
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem[rp_q[AW-1:0]];

  // Storage is written without reset; pointers guard validity.
  always_ff @(posedge pclk) begin
    if (in_valid && in_ready) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer updates.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Shift engine with an APB register port.
module bbs_shifter
  import bbs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             shift_clk,
  output logic             shift_data,
  output logic             shift_data_oe_n,
  input  wire logic        shift_data_in,
  output logic             seq_done
);
  typedef enum logic [3:0] {
    BBS_IDLE   = 4'b0001,
    BBS_SETUP  = 4'b0010,
    BBS_ACTIVE = 4'b0100,
    BBS_REST   = 4'b1000
  } bbs_state_t;

  bbs_state_t   state_q;
  logic [2:0]   mode_q;
  logic [15:0]  stretch_q;
  logic [31:0]  txdata_q;
  logic [31:0]  rxdata_q;
  logic [31:0]  sh_q;
  logic [5:0]   nbits_q;
  logic [5:0]   idx_q;
  logic         rx_q;
  logic         last_q;
  logic [31:0]  cnt_q;
  logic         done_q;
  logic [2:0]   din_q;
  logic         din_s;
  logic         wr;
  logic         rd;
  logic [BBS_FIFO_W-1:0] f_out;
  logic         f_valid;
  logic         f_ready;
  logic         f_in_ready;
  logic         push;
  logic [31:0]  act_run_q;

  // Zero bit count selects the default of eight.
  function automatic logic [5:0] eff_bits(input logic [5:0] b);
    // Counts above 32 clamp to 32.
    eff_bits = (b == 6'h00) ? BBS_DEFAULT_BITS : ((b > BBS_MAX_BITS) ? BBS_MAX_BITS : b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase; FIFO full stalls the item write.
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !pwrite;
  assign push    = wr && (paddr == BBS_REG_TXITEM);
  assign pready  = !(psel && pwrite && paddr == BBS_REG_TXITEM && !f_in_ready);
  assign pslverr = 1'b0;
  assign f_ready = (state_q == BBS_IDLE);

  bbs_fifo #(.W(BBS_FIFO_W), .D(BBS_FIFO_D)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   ({pwdata[BBS_ITEM_RX_BIT], pwdata[BBS_ITEM_LAST_BIT],
                 pwdata[BBS_ITEM_BITS_LSB +: 6], 2'h0, txdata_q}),
    .in_valid  (push && pready),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // Register writes; the item register is a queue push, not storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q    <= 3'h0;
      stretch_q <= BBS_STRETCH_RESET;
      txdata_q  <= 32'h00000000;
    end else if (wr && pready) begin
      if (paddr == BBS_REG_CTRL) begin
        mode_q <= pwdata[BBS_CTRL_MODE_LSB +: 3];
      end else if (paddr == BBS_REG_STRETCH) begin
        stretch_q <= pwdata[15:0];
      end else if (paddr == BBS_REG_TXDATA) begin
        txdata_q <= pwdata;
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd && !penable) begin
      if (paddr == BBS_REG_CTRL) begin
        prdata <= {29'h0, mode_q};
      end else if (paddr == BBS_REG_STRETCH) begin
        prdata <= {16'h0, stretch_q};
      end else if (paddr == BBS_REG_TXDATA) begin
        prdata <= txdata_q;
      end else if (paddr == BBS_REG_RXDATA) begin
        prdata <= rxdata_q;
      end else if (paddr == BBS_REG_STATUS) begin
        prdata <= {30'h0, f_valid, state_q != BBS_IDLE};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-in synchroniser; only the second and third stages are compared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_q <= 3'h0;
      din_s <= 1'b0;
    end else begin
      din_q <= {din_q[1:0], shift_data_in};
      if (din_q[1] == din_q[2]) begin
        din_s <= din_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit sequencer. Each bit: SETUP places data or pre-samples, ACTIVE holds
  // the clock pulse, REST returns to idle for the rest of the period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= BBS_IDLE;
      sh_q     <= 32'h00000000;
      nbits_q  <= 6'h00;
      idx_q    <= 6'h00;
      rx_q     <= 1'b0;
      last_q   <= 1'b0;
      cnt_q    <= 32'h00000000;
      rxdata_q <= 32'h00000000;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        BBS_IDLE: begin
          // Next queued item starts at once.
          if (f_valid) begin
            sh_q    <= f_out[31:0];
            nbits_q <= eff_bits(f_out[39:34]);
            idx_q   <= 6'h00;
            last_q  <= f_out[40];
            rx_q    <= f_out[41];
            if (f_out[41]) begin
              rxdata_q <= 32'h00000000;
            end
            state_q <= BBS_SETUP;
          end
        end
        BBS_SETUP: begin
          // Pre-sample modes read before the pulse.
          // Odd modes fill the low bit first.
          if (rx_q && !mode_q[BBS_MODE_POST_BIT]) begin
            rxdata_q <= mode_q[BBS_MODE_ORDER_BIT]
                        ? (rxdata_q | (32'h1 << idx_q))
                          & ~(32'(!din_s) << idx_q)
                        : {rxdata_q[30:0], din_s};
          end
          // Active phase of 2 us plus stretch.
          cnt_q   <= 32'(BBS_ACTIVE_CYC) + 32'(stretch_q) * 32'(BBS_CYC_PER_US) - 32'h1;
          state_q <= BBS_ACTIVE;
        end
        BBS_ACTIVE: begin
          if (cnt_q == 32'h0) begin
            // Post-sample modes read after the pulse.
            // Odd modes fill the low bit first.
            if (rx_q && mode_q[BBS_MODE_POST_BIT]) begin
              rxdata_q <= mode_q[BBS_MODE_ORDER_BIT]
                          ? (rxdata_q | (32'h1 << idx_q))
                            & ~(32'(!din_s) << idx_q)
                          : {rxdata_q[30:0], din_s};
            end
            cnt_q   <= 32'(BBS_IDLE_CYC) - 32'h1;
            state_q <= BBS_REST;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        BBS_REST: begin
          if (cnt_q == 32'h0) begin
            if (idx_q + 6'h1 == nbits_q) begin
              // Done after last bit of last item.
              done_q  <= last_q;
              state_q <= BBS_IDLE;
            end else begin
              idx_q   <= idx_q + 6'h1;
              state_q <= BBS_SETUP;
            end
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        default: state_q <= BBS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins. Clock is idle level except in ACTIVE.
  // Idle level from mode bit 2.
  assign shift_clk = mode_q[BBS_MODE_IDLE_BIT] ^ (state_q == BBS_ACTIVE);
  // Bit chosen from low-order bits, stable through the pulse.
  // Transmit order only; receive order is set in the sequencer.
  assign shift_data = mode_q[BBS_MODE_ORDER_BIT]
                      ? sh_q[5'(nbits_q - 6'h1 - idx_q)]
                      : sh_q[idx_q[4:0]];
  // Data pin driven only for transmit items; low enable means driving.
  assign shift_data_oe_n = (state_q == BBS_IDLE) || rx_q;
  assign seq_done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Pulse width counter. A repetition cannot span hundreds of cycles, so the
  // width checks below compare this count with the 2 us minimum and with the 2 us plus programmed stretch instead.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_run_q <= 32'h00000000;
    end else if (state_q == BBS_ACTIVE) begin
      act_run_q <= act_run_q + 32'h00000001;
    end else begin
      act_run_q <= 32'h00000000;
    end
  end

  sequence s_pulse_end;
    state_q == BBS_ACTIVE ##1 state_q == BBS_REST;
  endsequence

  chk_clk_idle_level: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == BBS_IDLE |-> shift_clk == mode_q[2])
    else $error("clock not at idle level");
  chk_clk_active: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == BBS_ACTIVE |-> shift_clk != mode_q[2])
    else $error("clock not active in pulse");
  chk_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == BBS_ACTIVE && !rx_q |=> $stable(shift_data) || state_q == BBS_REST)
    else $error("data moved during pulse");
  chk_active_min: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(state_q == BBS_ACTIVE) |-> act_run_q >= 32'(BBS_ACTIVE_CYC))
    else $error("active phase too short");
  chk_default_bits: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == BBS_IDLE && f_valid && f_out[39:34] == 6'h0 |=> nbits_q == 6'h08)
    else $error("default bit count wrong");
  chk_max_bits: assert property (@(posedge pclk) disable iff (!presetn)
    nbits_q <= 6'h20)
    else $error("bit count above limit");
  chk_done_idle: assert property (@(posedge pclk) disable iff (!presetn)
    seq_done |-> state_q == BBS_IDLE && shift_clk == mode_q[2])
    else $error("done without idle clock");
  chk_stretch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_pulse_end |-> act_run_q == 32'(BBS_ACTIVE_CYC) + 32'(stretch_q) * 32'(BBS_CYC_PER_US))
    else $error("pulse ended early");
  chk_lsb_first: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == BBS_SETUP && !mode_q[0] |-> shift_data == sh_q[idx_q[4:0]])
    else $error("low-first bit wrong");
  chk_rx_release: assert property (@(posedge pclk) disable iff (!presetn)
    rx_q && state_q != BBS_IDLE |-> shift_data_oe_n)
    else $error("data pin driven during receive");
  chk_tx_drive: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_q && state_q != BBS_IDLE |-> !shift_data_oe_n)
    else $error("data pin released during send");
  chk_done_once: assert property (@(posedge pclk) disable iff (!presetn)
    seq_done |=> !seq_done)
    else $error("done longer than one cycle");
endmodule

//--- bbs_pkg.sv
package bbs_pkg;
  // Command encodings for the item stream.
  localparam logic [0:0] BBS_CMD_TX = 1'h0;
  localparam logic [0:0] BBS_CMD_RX = 1'h1;
  // Mode bit positions.
  localparam int BBS_MODE_ORDER_BIT = 0;
  localparam int BBS_MODE_POST_BIT  = 1;
  localparam int BBS_MODE_IDLE_BIT  = 2;
  // Default bit count when none is given.
  localparam logic [5:0] BBS_DEFAULT_BITS = 6'h08;
  localparam logic [5:0] BBS_MAX_BITS     = 6'h20;
  // Timing.
  localparam int BBS_CLK_MHZ       = 250;
  localparam int BBS_ACTIVE_MIN_US = 2;
  localparam int BBS_CYC_PER_US    = BBS_CLK_MHZ;
  localparam int BBS_ACTIVE_CYC    = BBS_ACTIVE_MIN_US * BBS_CYC_PER_US;
  // Idle phase completes a roughly 50 kHz period (20 us).
  localparam int BBS_PERIOD_US     = 20;
  localparam int BBS_IDLE_CYC      = (BBS_PERIOD_US - BBS_ACTIVE_MIN_US) * BBS_CYC_PER_US;
  localparam logic [15:0] BBS_STRETCH_RESET = 16'h0000;
  // APB register offsets.
  localparam logic [7:0] BBS_REG_CTRL    = 8'h00;
  localparam logic [7:0] BBS_REG_STRETCH = 8'h04;
  localparam logic [7:0] BBS_REG_TXITEM  = 8'h08;
  localparam logic [7:0] BBS_REG_TXDATA  = 8'h0C;
  localparam logic [7:0] BBS_REG_RXDATA  = 8'h10;
  localparam logic [7:0] BBS_REG_STATUS  = 8'h14;
  // Field positions.
  localparam int BBS_CTRL_MODE_LSB = 0;
  localparam int BBS_ITEM_BITS_LSB = 0;
  localparam int BBS_ITEM_LAST_BIT = 8;
  localparam int BBS_ITEM_RX_BIT   = 9;
  localparam int BBS_FIFO_W = 42;
  localparam int BBS_FIFO_D = 16;
endpackage

//--- bbs_periph_model.sv
`timescale 1ns/100ps
// Serial peripheral model: takes a bit on each leading clock edge.
module bbs_periph_model (
  input  wire logic        pclk,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        si,
  input  wire logic        idle_hi,
  input  wire logic [31:0] pat,
  output logic             so,
  output logic [63:0]      cap,
  output logic [7:0]       nbits,
  output logic [31:0]      act_len,
  output logic             hold_err
);
  logic        prev_q = 1'b0;
  logic        held_q = 1'b0;
  logic        last_q = 1'b0;
  logic [31:0] cnt_q  = '0;
  wire         lead   = (sclk ^ idle_hi) & ~(prev_q ^ idle_hi);
  wire         trail  = ~(sclk ^ idle_hi) & (prev_q ^ idle_hi);
  // A released line shows the inverse of its last bit, so stale data never passes.
  // The next bit appears just after each leading edge, which sets pre and post apart.
  assign so = cs_n ? ~last_q : pat[nbits[4:0]];
  always_ff @(posedge pclk) begin
    prev_q <= sclk;
    if (cs_n) begin
      cap      <= '0;
      nbits    <= '0;
      hold_err <= 1'b0;
      cnt_q    <= '0;
    end else begin
      last_q <= so;
      if (lead) begin
        cap    <= {cap[62:0], si};
        nbits  <= nbits + 8'h01;
        held_q <= si;
        cnt_q  <= 32'h00000001;
      end else if (trail) begin
        act_len <= cnt_q;
      end else if (sclk ^ idle_hi) begin
        cnt_q <= cnt_q + 32'h00000001;
        if (si !== held_q) hold_err <= 1'b1;
      end
    end
  end
endmodule

//--- bitbang_sync_shifter_tb.sv
`timescale 1ns/100ps
// Bench for the shift engine; FIFO overflow is left out, each bit costs 5001 cycles plus 250 per microsecond of stretch.
module bitbang_sync_shifter_tb;
  import bbs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        cs_n = 1, idle_hi = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, pat = '0, rng = 32'h3675, q, d1, d2;
  int          miscompares = 0, comparisons = 0, cyc = 0;
  wire  [31:0] prdata, alen;
  wire  [63:0] cap;
  wire  [7:0]  nb;
  wire         pready, pslverr, sclk, sdat, oe_n, sdi, done, herr;
  wire         si = oe_n ? 1'b1 : sdat;

  bbs_shifter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shift_clk(sclk), .shift_data(sdat), .shift_data_oe_n(oe_n),
    .shift_data_in(sdi), .seq_done(done));
  bbs_periph_model i_per (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .si(si),
    .idle_hi(idle_hi), .pat(pat), .so(sdi), .cap(cap), .nbits(nb), .act_len(alen),
    .hold_err(herr));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a watchdog sized a little above the expected run.
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      miscompares++;
      final_report();
    end
  end

  // Stimulus generator, then expectation helpers worked out from the bit order and count alone.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] msk(input logic [31:0] v, input int n);
    return v & ((32'h00000001 << n) - 32'h00000001);
  endfunction
  function automatic logic [31:0] rev(input logic [31:0] v, input int n);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < n; i++) r[i] = v[n-1-i];
    return r;
  endfunction

  // Closing verdict, reached once from the main flow or the watchdog.
  task automatic final_report();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One APB transfer, entered just after a rising edge; held until pready is seen.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // Idle cycle, so a next call never reassigns psel in this step.
  endtask
  task automatic wait_done();
    do @(posedge pclk); while (done !== 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: registers, a two-item send, two receives, a low-first send.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, BBS_REG_STRETCH, 32'h0, q);
    chk(64'(q), 64'(BBS_STRETCH_RESET));
    apb(0, 8'h20, 32'h0, q);
    chk(64'(q), 64'h0);
    apb(0, BBS_REG_STATUS, 32'h0, q);
    chk(64'(q), 64'h0);
    chk(64'(pslverr), 64'h0);
    $display("test registers done");
    // High first, idle high, one microsecond of stretch.
    apb(1, BBS_REG_CTRL, 32'h5, q);
    idle_hi <= 1'b1;
    apb(1, BBS_REG_STRETCH, 32'h1, q);
    apb(0, BBS_REG_STRETCH, 32'h0, q);
    chk(64'(q), 64'h1);
    chk(64'(sclk), 64'h1);
    rng = xs(rng);
    d1 = rng;
    rng = xs(rng);
    d2 = rng;
    cs_n <= 1'b0;
    apb(1, BBS_REG_TXDATA, d1, q);
    apb(1, BBS_REG_TXITEM, 32'h2, q);
    apb(1, BBS_REG_TXDATA, d2, q);
    apb(1, BBS_REG_TXITEM, 32'h102, q);
    apb(0, BBS_REG_STATUS, 32'h0, q);
    chk(64'(q[0]), 64'h1);
    wait_done();
    chk(64'(sclk), 64'h1);
    chk(cap, (64'(msk(d1, 2)) << 2) | 64'(msk(d2, 2)));
    chk(64'(nb), 64'h4);
    chk(64'(alen), 64'(BBS_ACTIVE_CYC + BBS_CYC_PER_US));
    chk(64'(herr), 64'h0);
    cs_n <= 1'b1;
    $display("test send done");
    // Low first, sampled after the pulse, idle low.
    apb(1, BBS_REG_CTRL, 32'h3, q);
    idle_hi <= 1'b0;
    apb(1, BBS_REG_STRETCH, 32'h0, q);
    rng = xs(rng);
    pat <= rng;
    cs_n <= 1'b0;
    apb(1, BBS_REG_TXITEM, 32'h303, q);
    wait_done();
    chk(64'(sclk), 64'h0);
    chk(64'(alen), 64'(BBS_ACTIVE_CYC));
    apb(0, BBS_REG_RXDATA, 32'h0, q);
    chk(64'(q), 64'(msk(pat >> 1, 3)));
    cs_n <= 1'b1;
    $display("test receive post done");
    // High first, sampled before the pulse, idle high, default count.
    apb(1, BBS_REG_CTRL, 32'h4, q);
    idle_hi <= 1'b1;
    rng = xs(rng);
    pat <= rng;
    cs_n <= 1'b0;
    // The first bit is read before any pulse: let the pin pass the synchroniser.
    repeat (8) @(posedge pclk);
    apb(1, BBS_REG_TXITEM, 32'h300, q);
    wait_done();
    chk(64'(sclk), 64'h1);
    chk(64'(nb), 64'h8);
    apb(0, BBS_REG_RXDATA, 32'h0, q);
    chk(64'(q), 64'(rev(pat, 8)));
    cs_n <= 1'b1;
    $display("test receive pre done");
    // Low first, idle low: the send order that the other scenarios leave out.
    apb(1, BBS_REG_CTRL, 32'h0, q);
    idle_hi <= 1'b0;
    rng = xs(rng);
    d1 = rng;
    cs_n <= 1'b0;
    apb(1, BBS_REG_TXDATA, d1, q);
    apb(1, BBS_REG_TXITEM, 32'h102, q);
    wait_done();
    chk(64'(sclk), 64'h0);
    chk(cap, 64'(rev(d1, 2)));
    chk(64'(nb), 64'h2);
    chk(64'(herr), 64'h0);
    cs_n <= 1'b1;
    $display("test send low first done");
    final_report();
  end
endmodule
